// >>> src/cpcs_pkg.sv
// Shared constants and types for the PDO configuration and supervision block.
// Assumes a 100 MHz system clock and a single AHB-Lite slave port.
package cpcs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_TX_B_ID      = 8'h00;
  localparam logic [7:0] OFF_TX_B_TYPE    = 8'h04;
  localparam logic [7:0] OFF_TX_B_TIMER   = 8'h08;
  localparam logic [7:0] OFF_RX_C_ID      = 8'h0C;
  localparam logic [7:0] OFF_RX_C_TYPE    = 8'h10;
  localparam logic [7:0] OFF_RX_C_TIMEOUT = 8'h14;
  localparam logic [7:0] OFF_TX_C_ID      = 8'h18;
  localparam logic [7:0] OFF_TX_C_TYPE    = 8'h1C;
  localparam logic [7:0] OFF_TX_C_TIMER   = 8'h20;
  localparam logic [7:0] OFF_CTRL         = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h2C;
  localparam logic [7:0] OFF_STATE        = 8'h30;

  // Values after reset
  localparam logic [15:0] RST_ID    = 16'h0000;
  localparam logic [7:0]  RST_TYPE  = 8'hFF;
  localparam logic [15:0] RST_TIMER = 16'h0000;
  localparam logic [2:0]  RST_CTRL  = 3'h1;  // Local parameters selected, CANopen

  // Control register fields
  localparam int CTRL_LOCAL   = 0;  // Configuration source is local parameters
  localparam int CTRL_MODBUS  = 1;  // Serial protocol selected, PDO settings hidden
  localparam int CTRL_REFRESH = 2;  // Write one: apply settings (self clearing)

  // Interrupt status fields
  localparam int IRQ_RX_C_LOSS  = 0;
  localparam int IRQ_TX_B_FORCE = 1;
  localparam int IRQ_TX_C_FORCE = 2;
  localparam int IRQ_W          = 3;

  // Identifier setting codes
  localparam logic [10:0] ID_DISABLED = 11'h000;
  localparam logic [10:0] ID_PREDEF   = 11'h001;

  // Transmission type codes
  localparam logic [7:0] TT_ACYC_SYNC  = 8'h00;
  localparam logic [7:0] TT_CYC_MAX    = 8'hF0;
  localparam logic [7:0] TT_SYNC_RTR   = 8'hFC;
  localparam logic [7:0] TT_ASYNC_RTR  = 8'hFD;
  localparam logic [7:0] TT_ASYNC_MIN  = 8'hFE;

  // Millisecond tick
  localparam int MS_TIME_NS    = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CPCS_ACYC_SYNC,
    CPCS_CYC_SYNC,
    CPCS_SYNC_RTR,
    CPCS_ASYNC_RTR,
    CPCS_ASYNC,
    CPCS_RESERVED
  } cpcs_mode_t;

  // Active (applied) settings of one PDO
  typedef struct packed {
    logic        enabled;
    logic [10:0] cob_id;
    cpcs_mode_t  mode;
    logic [7:0]  sync_period;  // Sync count for cyclic mode
    logic [15:0] timer_ms;
  } cpcs_pdo_cfg_t;

endpackage : cpcs_pkg

// >>> src/cpcs_top.sv
// PDO configuration registers, settings apply logic and event timer supervision.
// Assumes a lone AHB-Lite master, one clock, and a frame engine that pulses
// reception and transmission events synchronous to clk.
//
// Function
// RULE1: Identifier zero disables the PDO, one uses predefined set, else literal.
// RULE2: Type 0 acyclic sync, 1-240 cyclic sync, 252/253 RTR, 254-255 async.
// RULE3: Enabled receive PDO silent for timer ms starts communication loss; zero disables.
// RULE4: Receive timeout armed only after first successful reception.
// RULE5: Enabled transmit PDO unsent for timer ms forces a transmission; zero disables.
// RULE6: Settings apply only with local source, after reboot or refresh command.
// RULE7: PDO settings are hidden when the serial Modbus protocol is selected.
// RULE8: Millisecond down-counters reload on traffic and refresh, fire on reaching zero.
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

module cpcs_top
  import cpcs_pkg::*;
#(
  parameter int          MS_DIV         = MS_CYCLES,
  parameter logic [10:0] PREDEF_TX_B_ID = 11'h100,
  parameter logic [10:0] PREDEF_RX_C_ID = 11'h200,
  parameter logic [10:0] PREDEF_TX_C_ID = 11'h300
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Frame engine events
  input  wire logic [6:0]  node_id,
  input  wire logic        rx_c_received,
  input  wire logic        tx_b_sent,
  input  wire logic        tx_c_sent,
  // Applied settings and supervision outputs
  output cpcs_pdo_cfg_t    tx_b_cfg,
  output cpcs_pdo_cfg_t    rx_c_cfg,
  output cpcs_pdo_cfg_t    tx_c_cfg,
  output logic             comm_loss_start,
  output logic             tx_b_force,
  output logic             tx_c_force,
  output logic             irq
);

  // Identifier resolution, shared by all three PDOs
  function automatic logic [11:0] resolve_id(input logic [15:0] setting,
                                              input logic [10:0] predef);
    logic [10:0] raw;
    raw = setting[10:0];
    if (raw == ID_DISABLED)
      resolve_id = {1'b0, 11'h000};                  // [RULE1]
    else if (raw == ID_PREDEF)
      resolve_id = {1'b1, predef + {4'h0, node_id}}; // [RULE1]
    else
      resolve_id = {1'b1, raw};                      // [RULE1]
  endfunction : resolve_id

  // Transmission type decode
  function automatic cpcs_mode_t decode_type(input logic [7:0] tt);
    if (tt == TT_ACYC_SYNC)
      decode_type = CPCS_ACYC_SYNC;  // [RULE2]
    else if (tt <= TT_CYC_MAX)
      decode_type = CPCS_CYC_SYNC;   // [RULE2]
    else if (tt == TT_SYNC_RTR)
      decode_type = CPCS_SYNC_RTR;   // [RULE2]
    else if (tt == TT_ASYNC_RTR)
      decode_type = CPCS_ASYNC_RTR;  // [RULE2]
    else if (tt >= TT_ASYNC_MIN)
      decode_type = CPCS_ASYNC;      // [RULE2]
    else
      decode_type = CPCS_RESERVED;
  endfunction : decode_type

  // Builds the applied form of one PDO's settings
  function automatic cpcs_pdo_cfg_t build_cfg(input logic [15:0] id_set,
                                               input logic [7:0]  tt,
                                               input logic [15:0] tmr,
                                               input logic [10:0] predef);
    logic [11:0] rid;
    rid = resolve_id(id_set, predef);
    build_cfg.enabled     = rid[11];
    build_cfg.cob_id      = rid[10:0];
    build_cfg.mode        = decode_type(tt);
    build_cfg.sync_period = (decode_type(tt) == CPCS_CYC_SYNC) ? tt : 8'h00;
    build_cfg.timer_ms    = tmr;
  endfunction : build_cfg

  // Millisecond down-counter step: {fire, next count}
  function automatic logic [16:0] timer_step(input logic [15:0] cnt,
                                              input logic [15:0] reload,
                                              input logic        restart,
                                              input logic        tick);
    if (restart)
      timer_step = {1'b0, reload};                    // [RULE8]
    else if (tick && cnt == 16'h0001)
      timer_step = {1'b1, reload};                    // [RULE8]
    else if (tick && cnt != 16'h0000)
      timer_step = {1'b0, cnt - 16'h0001};            // [RULE8]
    else
      timer_step = {1'b0, cnt};
  endfunction : timer_step

  // Written settings, control and interrupt registers
  logic [15:0]      tx_b_id_q, tx_b_timer_q, rx_c_id_q, rx_c_timeout_q;
  logic [15:0]      tx_c_id_q, tx_c_timer_q;
  logic [7:0]       tx_b_type_q, rx_c_type_q, tx_c_type_q;
  logic [1:0]       ctrl_q;
  logic [IRQ_W-1:0] irq_status_q, irq_mask_q;

  // Bus data phase state
  logic        dp_write_q, rd_wait_q;
  logic [7:0]  dp_addr_q;
  logic [31:0] hrdata_q;
  logic        addr_ok, wr_en, hidden, refresh;

  // Supervision state
  logic [31:0] ms_cnt_q;
  logic        ms_tick_q;
  logic [15:0] rx_c_cnt_q, tx_b_cnt_q, tx_c_cnt_q;
  logic        rx_c_armed_q;
  logic        loss_q, tx_b_force_q, tx_c_force_q;
  logic [16:0] rx_c_nx, tx_b_nx, tx_c_nx;
  logic [IRQ_W-1:0] events;

  // Address phase is taken only when the bus is ready and the slave selected
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_en   = dp_write_q;
  // Setting registers disappear from software view under the serial protocol
  assign hidden  = ctrl_q[CTRL_MODBUS];                                   // [RULE7]
  assign refresh = wr_en && dp_addr_q == OFF_CTRL && hwdata[CTRL_REFRESH]
                   && ctrl_q[CTRL_LOCAL];                                 // [RULE6]

  // Address phase capture; reads get one wait state so data is never stale
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dp_write_q <= 1'b0;
      dp_addr_q  <= 8'h00;
    end
    else if (addr_ok)
    begin
      dp_write_q <= hwrite;
      dp_addr_q  <= {haddr[7:2], 2'b00};
    end
    else if (hreadyout)
    begin
      dp_write_q <= 1'b0;
    end
  end

  // Read wait state marker
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_wait_q <= 1'b0;
    else
      rd_wait_q <= addr_ok && !hwrite;
  end

  assign hreadyout = !rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Read mux, sampled in the wait cycle after any write has landed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hrdata_q <= 32'h0000_0000;
    else if (rd_wait_q)
    begin
      case (dp_addr_q)
        OFF_TX_B_ID:      hrdata_q <= hidden ? 32'h0000_0000 : {16'h0000, tx_b_id_q};
        OFF_TX_B_TYPE:    hrdata_q <= hidden ? 32'h0000_0000 : {24'h00_0000, tx_b_type_q};
        OFF_TX_B_TIMER:   hrdata_q <= hidden ? 32'h0000_0000 : {16'h0000, tx_b_timer_q};
        OFF_RX_C_ID:      hrdata_q <= hidden ? 32'h0000_0000 : {16'h0000, rx_c_id_q};
        OFF_RX_C_TYPE:    hrdata_q <= hidden ? 32'h0000_0000 : {24'h00_0000, rx_c_type_q};
        OFF_RX_C_TIMEOUT: hrdata_q <= hidden ? 32'h0000_0000 : {16'h0000, rx_c_timeout_q};
        OFF_TX_C_ID:      hrdata_q <= hidden ? 32'h0000_0000 : {16'h0000, tx_c_id_q};
        OFF_TX_C_TYPE:    hrdata_q <= hidden ? 32'h0000_0000 : {24'h00_0000, tx_c_type_q};
        OFF_TX_C_TIMER:   hrdata_q <= hidden ? 32'h0000_0000 : {16'h0000, tx_c_timer_q};
        OFF_CTRL:         hrdata_q <= {30'h0000_0000, ctrl_q};
        OFF_IRQ_STATUS:   hrdata_q <= {29'h0000_0000, irq_status_q};
        OFF_IRQ_MASK:     hrdata_q <= {29'h0000_0000, irq_mask_q};
        OFF_STATE:        hrdata_q <= {28'h000_0000, rx_c_armed_q, tx_c_cfg.enabled,
                                       rx_c_cfg.enabled, tx_b_cfg.enabled};
        default:          hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Setting registers; writes are dropped while hidden
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_b_id_q      <= RST_ID;
      tx_b_type_q    <= RST_TYPE;
      tx_b_timer_q   <= RST_TIMER;
      rx_c_id_q      <= RST_ID;
      rx_c_type_q    <= RST_TYPE;
      rx_c_timeout_q <= RST_TIMER;
      tx_c_id_q      <= RST_ID;
      tx_c_type_q    <= RST_TYPE;
      tx_c_timer_q   <= RST_TIMER;
    end
    else if (wr_en && !hidden)                                          // [RULE7]
    begin
      case (dp_addr_q)
        OFF_TX_B_ID:      tx_b_id_q      <= hwdata[15:0];
        OFF_TX_B_TYPE:    tx_b_type_q    <= hwdata[7:0];
        OFF_TX_B_TIMER:   tx_b_timer_q   <= hwdata[15:0];
        OFF_RX_C_ID:      rx_c_id_q      <= hwdata[15:0];
        OFF_RX_C_TYPE:    rx_c_type_q    <= hwdata[7:0];
        OFF_RX_C_TIMEOUT: rx_c_timeout_q <= hwdata[15:0];
        OFF_TX_C_ID:      tx_c_id_q      <= hwdata[15:0];
        OFF_TX_C_TYPE:    tx_c_type_q    <= hwdata[7:0];
        OFF_TX_C_TIMER:   tx_c_timer_q   <= hwdata[15:0];
        default:          ;
      endcase
    end
  end

  // Control register; refresh bit is a command, never stored
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_q <= RST_CTRL[1:0];
    else if (wr_en && dp_addr_q == OFF_CTRL)
      ctrl_q <= hwdata[1:0];
  end

  // Applied settings: reset values act as the reboot image
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_b_cfg <= build_cfg(RST_ID, RST_TYPE, RST_TIMER, PREDEF_TX_B_ID);  // [RULE6]
      rx_c_cfg <= build_cfg(RST_ID, RST_TYPE, RST_TIMER, PREDEF_RX_C_ID);  // [RULE6]
      tx_c_cfg <= build_cfg(RST_ID, RST_TYPE, RST_TIMER, PREDEF_TX_C_ID);  // [RULE6]
    end
    else if (refresh)                                                     // [RULE6]
    begin
      tx_b_cfg <= build_cfg(tx_b_id_q, tx_b_type_q, tx_b_timer_q, PREDEF_TX_B_ID);
      rx_c_cfg <= build_cfg(rx_c_id_q, rx_c_type_q, rx_c_timeout_q, PREDEF_RX_C_ID);
      tx_c_cfg <= build_cfg(tx_c_id_q, tx_c_type_q, tx_c_timer_q, PREDEF_TX_C_ID);
    end
  end

  // Millisecond tick divider
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ms_cnt_q  <= 32'h0000_0000;
      ms_tick_q <= 1'b0;
    end
    else if (ms_cnt_q >= 32'(MS_DIV - 1))
    begin
      ms_cnt_q  <= 32'h0000_0000;
      ms_tick_q <= 1'b1;
    end
    else
    begin
      ms_cnt_q  <= ms_cnt_q + 32'h0000_0001;
      ms_tick_q <= 1'b0;
    end
  end

  // Next timer values; in the refresh cycle the restart takes the period applied before it
  assign rx_c_nx = timer_step(rx_c_cnt_q, rx_c_cfg.timer_ms,
                              refresh || rx_c_received, ms_tick_q);        // [RULE8]
  assign tx_b_nx = timer_step(tx_b_cnt_q, tx_b_cfg.timer_ms,
                              refresh || tx_b_sent, ms_tick_q);            // [RULE8]
  assign tx_c_nx = timer_step(tx_c_cnt_q, tx_c_cfg.timer_ms,
                              refresh || tx_c_sent, ms_tick_q);            // [RULE8]

  // Timer counters; reload picks up the old period in the refresh cycle
  // itself, so they load again one cycle later from the applied copy
  logic refresh_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      refresh_q  <= 1'b0;
      rx_c_cnt_q <= RST_TIMER;
      tx_b_cnt_q <= RST_TIMER;
      tx_c_cnt_q <= RST_TIMER;
    end
    else
    begin
      refresh_q  <= refresh;
      rx_c_cnt_q <= refresh_q ? rx_c_cfg.timer_ms : rx_c_nx[15:0];
      tx_b_cnt_q <= refresh_q ? tx_b_cfg.timer_ms : tx_b_nx[15:0];
      tx_c_cnt_q <= refresh_q ? tx_c_cfg.timer_ms : tx_c_nx[15:0];
    end
  end

  // Receive supervision arms on first reception, disarms after firing
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rx_c_armed_q <= 1'b0;
    else if (refresh || refresh_q)
      rx_c_armed_q <= 1'b0;                                             // [RULE4]
    else if (rx_c_received && rx_c_cfg.enabled)
      rx_c_armed_q <= 1'b1;                                             // [RULE4]
    else if (loss_q)
      rx_c_armed_q <= 1'b0;
  end

  // Event pulses; a zero period never fires because each pulse is gated on a nonzero applied period
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      loss_q       <= 1'b0;
      tx_b_force_q <= 1'b0;
      tx_c_force_q <= 1'b0;
    end
    else
    begin
      loss_q       <= rx_c_nx[16] && rx_c_armed_q && rx_c_cfg.enabled
                      && rx_c_cfg.timer_ms != 16'h0000 && !rx_c_received;  // [RULE3]
      tx_b_force_q <= tx_b_nx[16] && tx_b_cfg.enabled
                      && tx_b_cfg.timer_ms != 16'h0000;                    // [RULE5]
      tx_c_force_q <= tx_c_nx[16] && tx_c_cfg.enabled
                      && tx_c_cfg.timer_ms != 16'h0000;                    // [RULE5]
    end
  end

  assign comm_loss_start = loss_q;
  assign tx_b_force      = tx_b_force_q;
  assign tx_c_force      = tx_c_force_q;

  // Sticky status: a new event beats a same-cycle write-one clear
  assign events = {tx_c_force_q, tx_b_force_q, loss_q};
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_status_q <= 3'h0;
    else if (wr_en && dp_addr_q == OFF_IRQ_STATUS)
      irq_status_q <= (irq_status_q & ~hwdata[IRQ_W-1:0]) | events;
    else
      irq_status_q <= irq_status_q | events;
  end

  // Interrupt mask
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_mask_q <= 3'h0;
    else if (wr_en && dp_addr_q == OFF_IRQ_MASK)
      irq_mask_q <= hwdata[IRQ_W-1:0];
  end

  assign irq = |(irq_status_q & irq_mask_q);

endmodule : cpcs_top

`default_nettype wire

// >>> verif/cpcs_master_model.sv
// Network master model: sends rx_c frames on request, answers forced sends.
// Assumes force pulses of one cycle and send_delay of at least one.
`timescale 1ns/1ns
`default_nettype none
module cpcs_master_model
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rx_go,
  input  wire logic [3:0] send_delay,
  input  wire logic       tx_b_force,
  input  wire logic       tx_c_force,
  output logic            rx_c_received,
  output logic            tx_b_sent,
  output logic            tx_c_sent
);
  logic [3:0] wait_b_q;
  logic [3:0] wait_c_q;
  // Frame arrival one cycle after the request
  always_ff @(posedge clk)
    rx_c_received <= rst_n && rx_go;
  // Forced frame goes out later; the delay lets the bench be prompt or slow
  always_ff @(posedge clk)
  begin
    tx_b_sent <= rst_n && wait_b_q == 4'h1;
    tx_c_sent <= rst_n && wait_c_q == 4'h1;
    wait_b_q  <= !rst_n ? 4'h0 : tx_b_force ? send_delay : wait_b_q - (wait_b_q != 4'h0);
    wait_c_q  <= !rst_n ? 4'h0 : tx_c_force ? send_delay : wait_c_q - (wait_c_q != 4'h0);
  end
endmodule : cpcs_master_model
`default_nettype wire

// >>> verif/cpcs_monitor.sv
// Checker on the ports of cpcs_top: bus, apply and timer relations.
// Assumes hready is hreadyout fed back by the only bus master.
`timescale 1ns/1ns
`default_nettype none
module cpcs_monitor
  import cpcs_pkg::*;
#(
  parameter int MS_DIV = 10
)(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic          hreadyout,
  input wire logic [31:0]   hrdata,
  input wire logic          rx_c_received,
  input wire logic          tx_b_sent,
  input wire cpcs_pdo_cfg_t tx_b_cfg,
  input wire cpcs_pdo_cfg_t rx_c_cfg,
  input wire cpcs_pdo_cfg_t tx_c_cfg,
  input wire logic          comm_loss_start,
  input wire logic          tx_b_force,
  input wire logic          tx_c_force
);
  logic take;
  logic apply;
  logic ctrl_wr_q;
  logic local_q;
  logic hide_q;
  logic seen_q;
  int   since_q;
  int   lim;
  // Apply moment depends on the stored source bit, so shadow the control word
  assign take  = hsel && htrans[1] && hready;
  assign apply = ctrl_wr_q && hready && hwdata[CTRL_REFRESH] && local_q;
  assign lim   = int'(tx_b_cfg.timer_ms) * MS_DIV;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_wr_q <= 1'b0;
      local_q   <= 1'b1;
      hide_q    <= 1'b0;
    end
    else if (hready)
    begin
      ctrl_wr_q <= take && hwrite && haddr[7:0] == OFF_CTRL;
      if (ctrl_wr_q)
      begin
        local_q <= hwdata[CTRL_LOCAL];
        hide_q  <= hwdata[CTRL_MODBUS];
      end
    end
  end
  // Cycles since a reload cause; tick phase is unseen, hence the slack below
  always_ff @(posedge clk)
  begin
    seen_q  <= rst_n && (seen_q || rx_c_received);
    since_q <= (!rst_n || apply || tx_b_sent || tx_b_force) ? 0 : since_q + 1;
  end
  chk_read_wait: assert property (@(posedge clk) disable iff (!rst_n)
    take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  chk_apply_only:
    assert property (@(posedge clk) disable iff (!rst_n)
    !$stable(tx_b_cfg) || !$stable(rx_c_cfg) || !$stable(tx_c_cfg) |-> $past(apply))
    else $error("settings changed without refresh");
  chk_force_b_gate:
    assert property (@(posedge clk) disable iff (!rst_n)
    tx_b_force |-> $past(tx_b_cfg.enabled) && $past(tx_b_cfg.timer_ms) != 16'h0000)
    else $error("force on disabled tx_b");
  chk_force_c_gate:
    assert property (@(posedge clk) disable iff (!rst_n)
    tx_c_force |-> $past(tx_c_cfg.enabled) && $past(tx_c_cfg.timer_ms) != 16'h0000)
    else $error("force on disabled tx_c");
  chk_loss_gate:
    assert property (@(posedge clk) disable iff (!rst_n)
    comm_loss_start |-> $past(rx_c_cfg.enabled && rx_c_cfg.timer_ms != 16'h0000))
    else $error("loss on disabled rx_c");
  chk_loss_armed:
    assert property (@(posedge clk) disable iff (!rst_n) comm_loss_start |-> seen_q)
    else $error("loss before first reception");
  chk_force_early:
    assert property (@(posedge clk) disable iff (!rst_n)
    tx_b_force && !$past(apply) |-> since_q >= lim - MS_DIV - 1)
    else $error("tx_b forced too early");
  chk_force_late:
    assert property (@(posedge clk) disable iff (!rst_n)
    !(tx_b_cfg.enabled && lim != 0 && since_q > lim + 2))
    else $error("tx_b force missing");
  chk_hide_read:
    assert property (@(posedge clk) disable iff (!rst_n)
    take && !hwrite && haddr[7:0] <= OFF_TX_C_TIMER && hide_q |-> ##2 hrdata == 32'h0)
    else $error("hidden setting visible");
endmodule : cpcs_monitor
bind cpcs_top cpcs_monitor #(.MS_DIV(MS_DIV)) mon_u (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .rx_c_received(rx_c_received), .tx_b_sent(tx_b_sent),
  .tx_b_cfg(tx_b_cfg), .rx_c_cfg(rx_c_cfg), .tx_c_cfg(tx_c_cfg),
  .comm_loss_start(comm_loss_start), .tx_b_force(tx_b_force), .tx_c_force(tx_c_force));
`default_nettype wire

// >>> verif/test_canopen_pdo_config_supervision.sv
// Self-checking bench for cpcs_top; its tasks are the bus master.
// Assumes the checker is bound to cpcs_top and the master model answers.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("wrong value at %0t: compare failed", $time); \
    end \
  end
module test_canopen_pdo_config_supervision
  import cpcs_pkg::*;
;
  localparam int          MSD   = 10;
  localparam logic [10:0] PRE_B = 11'h140;
  logic          clk = 1'b0;
  logic          rst_n, hsel, hwrite, hreadyout, hresp, irq, rx_go;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [6:0]    node_id;
  logic [3:0]    send_delay;
  logic          rx_c_received, tx_b_sent, tx_c_sent;
  logic          comm_loss_start, tx_b_force, tx_c_force;
  cpcs_pdo_cfg_t tx_b_cfg, rx_c_cfg, tx_c_cfg;
  wire logic     hready;
  int            errors, check_count, cycles;
  assign hready = hreadyout;
  cpcs_top #(.MS_DIV(MSD), .PREDEF_TX_B_ID(PRE_B)) dut_u (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .node_id(node_id),
    .rx_c_received(rx_c_received), .tx_b_sent(tx_b_sent), .tx_c_sent(tx_c_sent),
    .tx_b_cfg(tx_b_cfg), .rx_c_cfg(rx_c_cfg), .tx_c_cfg(tx_c_cfg),
    .comm_loss_start(comm_loss_start), .tx_b_force(tx_b_force),
    .tx_c_force(tx_c_force), .irq(irq));
  cpcs_master_model peer_u (
    .clk(clk), .rst_n(rst_n), .rx_go(rx_go), .send_delay(send_delay),
    .tx_b_force(tx_b_force), .tx_c_force(tx_c_force), .rx_c_received(rx_c_received),
    .tx_b_sent(tx_b_sent), .tx_c_sent(tx_c_sent));
  always #5 clk = ~clk;
  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end
  task automatic close_out;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Single transfer: hold address until hready, then data until hready again
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    `CHK(v, e)
  endtask : rd_chk
  // Refresh command; returns once the applied settings have landed
  task automatic refresh;
    wr(OFF_CTRL, 32'h0000_0005);
    @(negedge clk);
  endtask : refresh
  task automatic wait_pulse(ref logic sig, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (sig !== 1'b1 && n < 400);
  endtask : wait_pulse
  task automatic frame;
    @(posedge clk) rx_go <= 1'b1;
    @(posedge clk) rx_go <= 1'b0;
    @(posedge clk);
  endtask : frame
  task automatic t_reset;
    wr(8'h3C, 32'hFFFF_FFFF);
    for (int i = 0; i < 16; i++)
      rd_chk(8'(i * 4), (i % 3 == 1 && i < 9) ? 32'h0000_00FF : 32'(i == 9));
    `CHK(tx_b_cfg.mode, CPCS_ASYNC)
    `CHK({hresp, irq, tx_b_cfg.enabled}, 3'h0)
  endtask : t_reset
  task automatic t_ident;
    wr(OFF_TX_B_ID, 32'h0000_0001);
    wr(OFF_RX_C_ID, 32'h0000_0123);
    wr(OFF_TX_C_ID, 32'h0000_0000);
    `CHK(rx_c_cfg.enabled, 1'b0)
    refresh();
    `CHK(tx_b_cfg.cob_id, PRE_B + 11'h005)
    `CHK(rx_c_cfg.cob_id, 11'h123)
    rd_chk(OFF_STATE, 32'h0000_0003);
  endtask : t_ident
  task automatic t_modes;
    logic [7:0] tt [8] = '{8'h00, 8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
    cpcs_mode_t md [8] = '{CPCS_ACYC_SYNC, CPCS_CYC_SYNC, CPCS_CYC_SYNC, CPCS_RESERVED,
                           CPCS_SYNC_RTR, CPCS_ASYNC_RTR, CPCS_ASYNC, CPCS_ASYNC};
    for (int i = 0; i < 8; i++)
    begin
      wr(OFF_TX_B_TYPE, {24'h00_0000, tt[i]});
      refresh();
      `CHK(tx_b_cfg.mode, md[i])
      if (md[i] == CPCS_CYC_SYNC)
        `CHK(tx_b_cfg.sync_period, tt[i])
    end
  endtask : t_modes
  task automatic t_local;
    wr(OFF_TX_B_TYPE, 32'h0000_00FD);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0004);
    @(negedge clk);
    `CHK(tx_b_cfg.mode, CPCS_ASYNC)
    wr(OFF_CTRL, 32'h0000_0001);
    refresh();
    `CHK(tx_b_cfg.mode, CPCS_ASYNC_RTR)
  endtask : t_local
  task automatic t_hide;
    wr(OFF_CTRL, 32'h0000_0003);
    rd_chk(OFF_TX_B_ID, 32'h0000_0000);
    wr(OFF_TX_B_ID, 32'h0000_0777);
    wr(OFF_CTRL, 32'h0000_0001);
    rd_chk(OFF_TX_B_ID, 32'h0000_0001);
    `CHK(tx_b_cfg.enabled, 1'b1)
  endtask : t_hide
  task automatic t_force;
    int n;
    int hit;
    logic [31:0] v;
    wr(OFF_TX_B_TIMER, 32'h0000_0003);
    wr(OFF_TX_C_ID, 32'h0000_0055);
    wr(OFF_TX_C_TIMER, 32'h0000_0005);
    refresh();
    wait_pulse(tx_b_force, n);
    `CHK(n inside {[2 * MSD + 1 : 3 * MSD + 2]}, 1'b1)
    wait_pulse(tx_b_sent, n);
    send_delay <= 4'hC;
    wait_pulse(tx_b_force, n);
    `CHK(n inside {[2 * MSD + 1 : 3 * MSD + 2]}, 1'b1)
    bus(1'b0, OFF_IRQ_STATUS, 32'h0000_0000, v);
    `CHK({v[IRQ_TX_C_FORCE], v[IRQ_TX_B_FORCE], irq}, 3'b110)
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    @(negedge clk);
    `CHK(irq, 1'b1)
    wr(OFF_TX_B_TIMER, 32'h0000_0000);
    wr(OFF_TX_C_TIMER, 32'h0000_0000);
    refresh();
    wr(OFF_IRQ_STATUS, 32'h0000_0007);
    @(negedge clk);
    `CHK(irq, 1'b0)
    hit = 0;
    repeat (60) @(posedge clk) hit += (tx_b_force === 1'b1);
    `CHK(hit, 0)
  endtask : t_force
  task automatic t_rx;
    int n;
    int hit;
    wr(OFF_RX_C_TIMEOUT, 32'h0000_0002);
    refresh();
    hit = 0;
    repeat (60) @(posedge clk) hit += (comm_loss_start === 1'b1);
    `CHK(hit, 0)
    for (int k = 0; k < 4; k++)
    begin
      frame();
      repeat (6) @(posedge clk) hit += (comm_loss_start === 1'b1);
    end
    `CHK(hit, 0)
    frame();
    wait_pulse(comm_loss_start, n);
    `CHK(n inside {[MSD + 1 : 2 * MSD + 2]}, 1'b1)
    rd_chk(OFF_STATE, 32'h0000_0007);
    rd_chk(OFF_IRQ_STATUS, 32'h0000_0001);
    `CHK(irq, 1'b0)
  endtask : t_rx
  initial
  begin
    {rst_n, hsel, hwrite, rx_go, haddr, hwdata, htrans} = '0;
    hsize      = 3'h2;
    node_id    = 7'h05;
    send_delay = 4'h4;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ident();
    t_modes();
    t_local();
    t_hide();
    t_force();
    t_rx();
    close_out();
  end
endmodule : test_canopen_pdo_config_supervision
`default_nettype wire
